// File: hdl/comparator_dac_pkg.sv
// Summary of operation
// - Hysteresis output follows the hysteresis-enable bit of each comparator that is on; it is held low while off.
// - Processed comparator output is offered to the gate timer as a gate source.
// - With sync enabled, output passes through a latch clocked by gate timer clock.
// - Latch captures on falling edge of timer clock; timer counts on rising.
// - Latch uses the prescaled timer clock when the timer prescales.
// - Rising and falling edge detectors; an enabled edge sets the interrupt flag.
// - Flag cleared only by software; an edge during the clear keeps it set.
// - Three-bit positive select routes pin, DAC, fixed reference or ground.
// - A comparator that is off has all its inputs disconnected.
// - Toggling polarity or on bit while off still gives an interrupt edge.
// - Mirror register shows four outputs in bits 3..0; bits 7..4 read zero.
// - DAC positive source: 00 supply, 01 positive pin, 10 buffer; 11 reserved.
// - DAC negative source: 1 selects negative pin, 0 selects ground.
// - Eight-bit DAC level field selects the DAC output step.
package comparator_dac_pkg;

    localparam int NUM_COMP = 4;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int REG_W    = 8;

    localparam logic [ADDR_W-1:0] CTRL0_BASE      = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL1_BASE      = 8'h04;
    localparam logic [ADDR_W-1:0] CTRL_STRIDE     = 8'h08;
    localparam logic [ADDR_W-1:0] MIRROR_ADDR     = 8'h20;
    localparam logic [ADDR_W-1:0] DAC_SRC_ADDR    = 8'h24;
    localparam logic [ADDR_W-1:0] DAC_LEVEL_ADDR  = 8'h28;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 8'h2c;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR   = 8'h30;

    localparam logic [REG_W-1:0]    CTRL0_RST     = 8'h00;
    localparam logic [REG_W-1:0]    CTRL1_RST     = 8'h00;
    localparam logic [REG_W-1:0]    DAC_SRC_RST   = 8'h00;
    localparam logic [REG_W-1:0]    DAC_LEVEL_RST = 8'h00;
    localparam logic [NUM_COMP-1:0] FLAGS_RST     = 4'h0;

    localparam logic [2:0] PCH_PIN       = 3'h0;
    localparam logic [2:0] PCH_DAC       = 3'h1;
    localparam logic [2:0] PCH_FIXED_REF = 3'h2;

    // One-hot routing of the non-inverting input
    localparam logic [3:0] ROUTE_NONE      = 4'h0;
    localparam logic [3:0] ROUTE_PIN       = 4'h1;
    localparam logic [3:0] ROUTE_DAC       = 4'h2;
    localparam logic [3:0] ROUTE_FIXED_REF = 4'h4;
    localparam logic [3:0] ROUTE_GND       = 4'h8;

    localparam logic [1:0] DAC_PSS_SUPPLY   = 2'h0;
    localparam logic [1:0] DAC_PSS_REF_PIN  = 2'h1;
    localparam logic [1:0] DAC_PSS_BUFFER   = 2'h2;
    localparam logic [1:0] DAC_PSS_RESERVED = 2'h3;

    typedef struct packed {
        logic comparator_on;
        logic comparator_result;
        logic pin_output_enable;
        logic output_polarity;
        logic zero_latency_filter;
        logic speed_power_select;
        logic hysteresis_enable;
        logic output_sync_enable;
    } ctrl0_s;

    typedef struct packed {
        logic       rising_edge_int_enable;
        logic       falling_edge_int_enable;
        logic [2:0] positive_input_select;
        logic [2:0] negative_input_select;
    } ctrl1_s;

    typedef struct packed {
        logic       dac_enable;
        logic       unused6;
        logic       dac_out1_enable;
        logic       dac_out2_enable;
        logic [1:0] dac_positive_source;
        logic       unused1;
        logic       dac_negative_source;
    } dac_src_s;

    typedef struct packed {
        logic       comparator_on;
        logic       hysteresis_enable;
        logic       speed_power_select;
        logic       zero_latency_filter;
        logic [3:0] positive_route;
        logic [2:0] negative_input_select;
    } comp_analog_s;

    typedef struct packed {
        logic       dac_enable;
        logic       dac_out1_enable;
        logic       dac_out2_enable;
        logic [1:0] dac_positive_source;
        logic       dac_negative_source;
        logic [7:0] dac_level;
    } dac_analog_s;

endpackage : comparator_dac_pkg

// File: hdl/comparator_channel.sv
`timescale 1ns/1ps
module comparator_channel (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic raw_result_i,
    input  wire logic comparator_on_i,
    input  wire logic output_polarity_i,
    input  wire logic output_sync_enable_i,
    input  wire logic timer_fall_i,
    input  wire logic rising_en_i,
    input  wire logic falling_en_i,
    output logic      level_o,
    output logic      result_o,
    output logic      edge_event_o
);

    logic result_r;
    logic result_nxt;

    // Core reads low while off, so polarity alone sets the level
    assign level_o = (raw_result_i & comparator_on_i) ^ output_polarity_i;
    assign result_nxt = output_sync_enable_i ?
                        (timer_fall_i ? level_o : result_r) : level_o;
    assign edge_event_o = (result_nxt & ~result_r & rising_en_i) |
                          (~result_nxt & result_r & falling_en_i);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            result_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
        end
    end

    assign result_o = result_r;

endmodule : comparator_channel

// File: hdl/comparator_dac_control.sv
`timescale 1ns/1ps
module comparator_dac_control (
    input  wire logic                                         core_clk_i,
    input  wire logic                                         reset_i,
    input  wire logic                                         psel_i,
    input  wire logic                                         penable_i,
    input  wire logic                                         pwrite_i,
    input  wire logic [comparator_dac_pkg::ADDR_W-1:0]         paddr_i,
    input  wire logic [comparator_dac_pkg::DATA_W-1:0]         pwdata_i,
    output logic      [comparator_dac_pkg::DATA_W-1:0]         prdata_o,
    output logic                                              pready_o,
    output logic                                              pslverr_o,
    input  wire logic [comparator_dac_pkg::NUM_COMP-1:0]       raw_result_i,
    input  wire logic                                         timer_clk_i,
    output comparator_dac_pkg::comp_analog_s [comparator_dac_pkg::NUM_COMP-1:0] analog_o,
    output logic      [comparator_dac_pkg::NUM_COMP-1:0]       gate_source_o,
    output logic      [comparator_dac_pkg::NUM_COMP-1:0]       comp_pin_o,
    output comparator_dac_pkg::dac_analog_s                    dac_o,
    output logic                                              irq_o
);

    localparam int NC = comparator_dac_pkg::NUM_COMP;
    localparam int RW = comparator_dac_pkg::REG_W;

    comparator_dac_pkg::ctrl0_s   ctrl0_r [NC];
    comparator_dac_pkg::ctrl1_s   ctrl1_r [NC];
    comparator_dac_pkg::dac_src_s dac_src_r;
    comparator_dac_pkg::dac_src_s dac_src_wr;
    comparator_dac_pkg::dac_src_s dac_src_nxt;
    comparator_dac_pkg::ctrl0_s   wr_ctrl0;
    logic [RW-1:0]                dac_level_r;
    logic [NC-1:0]                flag_r;
    logic [NC-1:0]                flag_nxt;
    logic [NC-1:0]                mask_r;
    logic [NC-1:0]                clear_w;
    logic [NC-1:0]                event_w;
    logic [NC-1:0]                result_w;
    logic [NC-1:0]                level_w;
    logic [NC-1:0]                hit0;
    logic [NC-1:0]                hit1;
    logic [RW-1:0]                rd_ctrl0 [NC];
    logic [RW-1:0]                rd_ctrl1 [NC];
    logic [RW-1:0]                rd_ctrl;
    logic [RW-1:0]                rd_byte;
    logic                         timer_clk_r;
    logic                         timer_fall;
    logic                         access;
    logic                         wr_en;
    logic                         hit_mirror;
    logic                         hit_dac_src;
    logic                         hit_dac_level;
    logic                         hit_status;
    logic                         hit_mask;
    logic                         mapped;

    // Zero-wait APB slave
    assign access        = psel_i & penable_i;
    assign wr_en         = access & pwrite_i;
    assign hit_mirror    = (paddr_i == comparator_dac_pkg::MIRROR_ADDR);
    assign hit_dac_src   = (paddr_i == comparator_dac_pkg::DAC_SRC_ADDR);
    assign hit_dac_level = (paddr_i == comparator_dac_pkg::DAC_LEVEL_ADDR);
    assign hit_status    = (paddr_i == comparator_dac_pkg::INT_STATUS_ADDR);
    assign hit_mask      = (paddr_i == comparator_dac_pkg::INT_MASK_ADDR);
    assign mapped        = (|hit0) | (|hit1) | hit_mirror | hit_dac_src |
                           hit_dac_level | hit_status | hit_mask;
    assign pready_o      = 1'b1;
    assign pslverr_o     = access & ~mapped;
    assign wr_ctrl0      = comparator_dac_pkg::ctrl0_s'(pwdata_i[RW-1:0]);

    // Falling edge of the (prescaled) gate timer clock
    assign timer_fall = timer_clk_r & ~timer_clk_i;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_clk_r <= 1'b0;
        end else begin
            timer_clk_r <= timer_clk_i;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_comp
            assign hit0[gi] = (paddr_i == comparator_dac_pkg::CTRL0_BASE +
                               8'(gi) * comparator_dac_pkg::CTRL_STRIDE);
            assign hit1[gi] = (paddr_i == comparator_dac_pkg::CTRL1_BASE +
                               8'(gi) * comparator_dac_pkg::CTRL_STRIDE);

            always_ff @(posedge core_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ctrl0_r[gi] <= comparator_dac_pkg::ctrl0_s'(comparator_dac_pkg::CTRL0_RST);
                    ctrl1_r[gi] <= comparator_dac_pkg::ctrl1_s'(comparator_dac_pkg::CTRL1_RST);
                end else begin
                    if (wr_en && hit0[gi]) begin
                        ctrl0_r[gi] <= wr_ctrl0;
                    end
                    if (wr_en && hit1[gi]) begin
                        ctrl1_r[gi] <= comparator_dac_pkg::ctrl1_s'(pwdata_i[RW-1:0]);
                    end
                end
            end

            comparator_channel u_channel (
                .core_clk_i           (core_clk_i),
                .reset_i              (reset_i),
                .raw_result_i         (raw_result_i[gi]),
                .comparator_on_i      (ctrl0_r[gi].comparator_on),
                .output_polarity_i    (ctrl0_r[gi].output_polarity),
                .output_sync_enable_i (ctrl0_r[gi].output_sync_enable),
                .timer_fall_i         (timer_fall),
                .rising_en_i          (ctrl1_r[gi].rising_edge_int_enable),
                .falling_en_i         (ctrl1_r[gi].falling_edge_int_enable),
                .level_o              (level_w[gi]),
                .result_o             (result_w[gi]),
                .edge_event_o         (event_w[gi])
            );

            // Result bit is read-only and shows the processed output
            assign rd_ctrl0[gi] = {ctrl0_r[gi].comparator_on, result_w[gi],
                                   ctrl0_r[gi][RW-3:0]};
            assign rd_ctrl1[gi] = ctrl1_r[gi];

            assign analog_o[gi].comparator_on       = ctrl0_r[gi].comparator_on;
            assign analog_o[gi].hysteresis_enable   = ctrl0_r[gi].comparator_on &
                                                      ctrl0_r[gi].hysteresis_enable;
            assign analog_o[gi].speed_power_select  = ctrl0_r[gi].speed_power_select;
            assign analog_o[gi].zero_latency_filter = ctrl0_r[gi].zero_latency_filter;
            assign analog_o[gi].positive_route      =
                !ctrl0_r[gi].comparator_on ? comparator_dac_pkg::ROUTE_NONE :
                (ctrl1_r[gi].positive_input_select == comparator_dac_pkg::PCH_PIN) ?
                    comparator_dac_pkg::ROUTE_PIN :
                (ctrl1_r[gi].positive_input_select == comparator_dac_pkg::PCH_DAC) ?
                    comparator_dac_pkg::ROUTE_DAC :
                (ctrl1_r[gi].positive_input_select == comparator_dac_pkg::PCH_FIXED_REF) ?
                    comparator_dac_pkg::ROUTE_FIXED_REF :
                    comparator_dac_pkg::ROUTE_GND;
            assign analog_o[gi].negative_input_select =
                ctrl0_r[gi].comparator_on ? ctrl1_r[gi].negative_input_select : 3'h0;
            assign comp_pin_o[gi] = result_w[gi] & ctrl0_r[gi].pin_output_enable;
        end
    endgenerate

    assign gate_source_o = result_w;

    always_comb begin
        rd_ctrl = '0;
        for (int i = 0; i < NC; i++) begin
            rd_ctrl = rd_ctrl | ({RW{hit0[i]}} & rd_ctrl0[i]) | ({RW{hit1[i]}} & rd_ctrl1[i]);
        end
    end

    assign rd_byte = rd_ctrl |
        ({RW{hit_mirror}}    & {{(RW-NC){1'b0}}, result_w}) |
        ({RW{hit_dac_src}}   & dac_src_r) |
        ({RW{hit_dac_level}} & dac_level_r) |
        ({RW{hit_status}}    & {{(RW-NC){1'b0}}, flag_r}) |
        ({RW{hit_mask}}      & {{(RW-NC){1'b0}}, mask_r});
    assign prdata_o = {{(comparator_dac_pkg::DATA_W-RW){1'b0}}, rd_byte};

    // Reserved source code is refused and the old selection kept
    assign dac_src_wr  = comparator_dac_pkg::dac_src_s'(pwdata_i[RW-1:0]);
    assign dac_src_nxt = '{dac_enable:          dac_src_wr.dac_enable,
                           unused6:             1'b0,
                           dac_out1_enable:     dac_src_wr.dac_out1_enable,
                           dac_out2_enable:     dac_src_wr.dac_out2_enable,
                           dac_positive_source:
                               (dac_src_wr.dac_positive_source ==
                                comparator_dac_pkg::DAC_PSS_RESERVED) ?
                               dac_src_r.dac_positive_source :
                               dac_src_wr.dac_positive_source,
                           unused1:             1'b0,
                           dac_negative_source: dac_src_wr.dac_negative_source};

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_src_r   <= comparator_dac_pkg::dac_src_s'(comparator_dac_pkg::DAC_SRC_RST);
            dac_level_r <= comparator_dac_pkg::DAC_LEVEL_RST;
        end else begin
            if (wr_en && hit_dac_src) begin
                dac_src_r <= dac_src_nxt;
            end
            if (wr_en && hit_dac_level) begin
                dac_level_r <= pwdata_i[RW-1:0];
            end
        end
    end

    assign dac_o.dac_enable          = dac_src_r.dac_enable;
    assign dac_o.dac_out1_enable     = dac_src_r.dac_out1_enable;
    assign dac_o.dac_out2_enable     = dac_src_r.dac_out2_enable;
    assign dac_o.dac_positive_source = dac_src_r.dac_positive_source;
    assign dac_o.dac_negative_source = dac_src_r.dac_negative_source;
    assign dac_o.dac_level           = dac_level_r;

    // Write-one-to-clear flags; a new edge beats the clear
    assign clear_w  = (wr_en && hit_status) ? pwdata_i[NC-1:0] : '0;
    assign flag_nxt = (flag_r & ~clear_w) | event_w;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_r <= comparator_dac_pkg::FLAGS_RST;
            mask_r <= comparator_dac_pkg::FLAGS_RST;
        end else begin
            flag_r <= flag_nxt;
            if (wr_en && hit_mask) begin
                mask_r <= pwdata_i[NC-1:0];
            end
        end
    end

    assign irq_o = |(flag_r & mask_r);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_hys_follows_write: assert property (
        wr_en && hit0[0] |=> analog_o[0].hysteresis_enable ==
            ($past(wr_ctrl0.hysteresis_enable) && $past(wr_ctrl0.comparator_on)))
        else $error("hysteresis output does not follow written bit");

    a_gate_src_direct: assert property (
        !ctrl0_r[0].output_sync_enable |=> gate_source_o[0] == $past(level_w[0]))
        else $error("unsynchronised gate source wrong");

    a_sync_holds_value: assert property (
        ctrl0_r[0].output_sync_enable && !timer_fall |=> $stable(result_w[0]))
        else $error("synchronised output changed without timer falling edge");

    a_sync_falling_capture: assert property (
        ctrl0_r[0].output_sync_enable && timer_fall |=> result_w[0] == $past(level_w[0]))
        else $error("synchronised output not captured on timer falling edge");

    a_edge_sets_flag: assert property (
        event_w != '0 |=> (flag_r & $past(event_w)) == $past(event_w))
        else $error("enabled edge did not set flag");

    a_flag_clear_cause: assert property (
        ($past(flag_r) & ~flag_r) != '0 |-> $past(wr_en) && $past(hit_status))
        else $error("flag fell without a clearing write");

    a_clear_takes_effect: assert property (
        wr_en && hit_status && event_w == '0 |=> (flag_r & $past(clear_w)) == '0)
        else $error("clearing write did not clear flag");

    a_off_inputs_open: assert property (
        !ctrl0_r[0].comparator_on |-> analog_o[0].positive_route ==
            comparator_dac_pkg::ROUTE_NONE && analog_o[0].negative_input_select == 3'h0)
        else $error("disabled comparator inputs connected");

    a_off_polarity_edge: assert property (
        !ctrl0_r[0].comparator_on && !ctrl0_r[0].output_sync_enable |=>
            result_w[0] == $past(ctrl0_r[0].output_polarity))
        else $error("polarity of disabled comparator not reflected");

    a_mirror_read_value: assert property (
        access && !pwrite_i && hit_mirror |->
            prdata_o == {{(comparator_dac_pkg::DATA_W-NC){1'b0}}, result_w})
        else $error("mirror read wrong");

    a_dac_no_reserved: assert property (
        dac_o.dac_positive_source != comparator_dac_pkg::DAC_PSS_RESERVED)
        else $error("reserved DAC source selected");

    a_dac_level_write: assert property (
        wr_en && hit_dac_level |=> dac_o.dac_level == $past(pwdata_i[RW-1:0]))
        else $error("DAC level not updated");

    a_hys_off_when_off: assert property (
        !ctrl0_r[2].comparator_on |-> !analog_o[2].hysteresis_enable)
        else $error("hysteresis on disabled comparator");

    a_hys_when_on: assert property (
        ctrl0_r[2].comparator_on |->
            analog_o[2].hysteresis_enable == ctrl0_r[2].hysteresis_enable)
        else $error("hysteresis does not follow its bit");

    a_timer_fall_seen: assert property (
        $past(timer_clk_i) && !timer_clk_i |-> timer_fall)
        else $error("timer clock fall missed");

    a_route_pin: assert property (
        ctrl0_r[2].comparator_on &&
            ctrl1_r[2].positive_input_select == comparator_dac_pkg::PCH_PIN |->
            analog_o[2].positive_route == comparator_dac_pkg::ROUTE_PIN)
        else $error("pin code not routed to pin");

    a_route_dac: assert property (
        ctrl0_r[2].comparator_on &&
            ctrl1_r[2].positive_input_select == comparator_dac_pkg::PCH_DAC |->
            analog_o[2].positive_route == comparator_dac_pkg::ROUTE_DAC)
        else $error("DAC code not routed to DAC");

    a_route_ground: assert property (
        ctrl0_r[2].comparator_on &&
            ctrl1_r[2].positive_input_select > comparator_dac_pkg::PCH_FIXED_REF |->
            analog_o[2].positive_route == comparator_dac_pkg::ROUTE_GND)
        else $error("other codes not routed to ground");

    a_level_follows_raw: assert property (
        ctrl0_r[0].comparator_on && !ctrl0_r[0].output_sync_enable |=>
            result_w[0] == ($past(raw_result_i[0]) ^ $past(ctrl0_r[0].output_polarity)))
        else $error("result does not follow raw output and polarity");

    a_result_readback: assert property (
        access && hit0[0] |-> prdata_o[RW-2] == result_w[0])
        else $error("result bit read back wrong");

    a_mirror_upper_zero: assert property (
        access && hit_mirror |-> prdata_o[RW-1:NC] == '0)
        else $error("mirror upper bits not zero");

    a_set_beats_clear: assert property (
        wr_en && hit_status && (clear_w & event_w) != '0 |=>
            (flag_r & $past(clear_w & event_w)) == $past(clear_w & event_w))
        else $error("clearing write beat a new edge");

    a_off_toggle_flags: assert property (
        !ctrl0_r[0].comparator_on && !ctrl0_r[0].output_sync_enable &&
            ctrl1_r[0].rising_edge_int_enable && $rose(ctrl0_r[0].output_polarity) &&
            !result_w[0] |=> flag_r[0])
        else $error("polarity toggle while off gave no flag");

    a_reserved_kept: assert property (
        wr_en && hit_dac_src &&
            dac_src_wr.dac_positive_source == comparator_dac_pkg::DAC_PSS_RESERVED |=>
            $stable(dac_o.dac_positive_source))
        else $error("reserved code changed DAC source");

    a_dac_neg_write: assert property (
        wr_en && hit_dac_src |=>
            dac_o.dac_negative_source == $past(dac_src_wr.dac_negative_source))
        else $error("DAC negative source not updated");

    c_flag_raised: cover property (event_w[0] && !flag_r[0]);
    c_sync_capture: cover property (ctrl0_r[0].output_sync_enable && timer_fall &&
                                    level_w[0] != result_w[0]);
    c_irq_rises: cover property ($rose(irq_o));
    c_clear_collides: cover property (wr_en && hit_status && (clear_w & event_w) != '0);
    c_reserved_write: cover property (wr_en && hit_dac_src &&
        dac_src_wr.dac_positive_source == comparator_dac_pkg::DAC_PSS_RESERVED);

endmodule : comparator_dac_control

// File: test/analog_partner.sv
`timescale 1ns/1ps
module analog_partner #(
    parameter int PRESCALE = 3
) (
    input  wire logic       core_clk_i,
    input  wire logic       timer_run_i,
    input  wire logic [3:0] raw_cmd_i,
    output logic      [3:0] raw_result_o,
    output logic            timer_clk_o
);
    logic [7:0] div_r;

    // Prescaled gate timer clock, parked high while stopped
    always_ff @(posedge core_clk_i) begin
        if (!timer_run_i) begin
            div_r       <= 8'h00;
            timer_clk_o <= 1'b1;
        end else if (div_r == 8'(PRESCALE - 1)) begin
            div_r       <= 8'h00;
            timer_clk_o <= ~timer_clk_o;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Comparator cores settle one cycle after being commanded
    always_ff @(posedge core_clk_i) begin
        raw_result_o <= raw_cmd_i;
    end
endmodule : analog_partner

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        trun    = 1'b0;
    logic [3:0]  raw_cmd = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  raw;
    logic        tclk;
    logic [3:0]  gate;
    logic [3:0]  pin;
    logic        irq;
    logic [7:0]  v;
    logic [32:0] exp_q[$];
    logic [7:0]  addrs[7] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
    int          errors = 0;
    int          checks_done = 0;
    int          n;
    comparator_dac_pkg::comp_analog_s [3:0] analog;
    comparator_dac_pkg::dac_analog_s        dac;

    always #12.5 clk = ~clk;

    comparator_dac_control i_comparator_dac_control (.core_clk_i(clk), .reset_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .raw_result_i(raw), .timer_clk_i(tclk), .analog_o(analog), .gate_source_o(gate),
        .comp_pin_o(pin), .dac_o(dac), .irq_o(irq));

    analog_partner #(.PRESCALE(3)) i_analog_partner (.core_clk_i(clk), .timer_run_i(trun),
        .raw_cmd_i(raw_cmd), .raw_result_o(raw), .timer_clk_o(tclk));

    task chk_bus(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bus got %h expected %h", $time, got, exp);
        end
    endtask : chk_bus

    task chk_sig(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: signal got %h expected %h", $time, got, exp);
        end
    endtask : chk_sig

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task settle;
        @(negedge clk);
    endtask : settle

    task end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Read data and error flag judged at the accepting edge
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_bus({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        #500000;
        errors++;
        end_of_test;
    end

    initial begin
        void'($urandom(74607));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 7; n++) rd(addrs[n], 32'h0);
        apb(1'b0, 8'h34, 32'h0, {1'b1, 32'h0});
        wr(8'h20, 32'hff);
        rd(8'h20, 32'h0);
        $display("test reset done");
        for (n = 0; n < 3; n++) begin
            v = {n[0], 1'b0, n[1], n[0], n[1:0], 1'b0, n[0]};
            wr(8'h24, {24'h0, v});
            settle;
            chk_sig({6'h0, dac.dac_positive_source}, {6'h0, n[1:0]});
            chk_sig({7'h0, dac.dac_negative_source}, {7'h0, n[0]});
            chk_sig({5'h0, dac.dac_enable, dac.dac_out1_enable, dac.dac_out2_enable},
                    {5'h0, n[0], n[1], n[0]});
        end
        wr(8'h24, 32'h0c);
        rd(8'h24, 32'h08);
        v = 8'($urandom);
        wr(8'h28, {24'h0, v});
        rd(8'h28, {24'h0, v});
        settle;
        chk_sig(dac.dac_level, v);
        $display("test dac done");
        for (n = 0; n < 4; n++) begin
            wr(8'h14, {26'h0, (n == 3) ? 3'($urandom_range(7, 3)) : 3'(n), 3'h0});
            wr(8'h10, 32'h86);
            settle;
            chk_sig({4'h0, analog[2].positive_route}, 8'h01 << n);
            chk_sig({7'h0, analog[2].hysteresis_enable}, 8'h01);
        end
        wr(8'h10, 32'h02);
        settle;
        chk_sig({4'h0, analog[2].positive_route}, 8'h00);
        chk_sig({7'h0, analog[2].hysteresis_enable}, 8'h00);
        $display("test routing done");
        wr(8'h30, 32'h01);
        wr(8'h04, 32'hc0);
        wr(8'h00, 32'ha0);
        @(posedge clk);
        raw_cmd <= 4'h1;
        repeat (4) @(posedge clk);
        settle;
        chk_sig({4'h0, gate}, 8'h01);
        chk_sig({7'h0, irq}, 8'h01);
        chk_sig({4'h0, pin}, 8'h01);
        rd(8'h2c, 32'h01);
        rd(8'h20, 32'h01);
        rd(8'h00, 32'he0);
        wr(8'h2c, 32'h01);
        rd(8'h2c, 32'h00);
        settle;
        chk_sig({7'h0, irq}, 8'h00);
        wr(8'h00, 32'h00);
        rd(8'h2c, 32'h01);
        wr(8'h2c, 32'h01);
        wr(8'h00, 32'h10);
        rd(8'h2c, 32'h01);
        wr(8'h2c, 32'h01);
        wr(8'h30, 32'h00);
        wr(8'h00, 32'h00);
        rd(8'h2c, 32'h01);
        settle;
        chk_sig({7'h0, irq}, 8'h00);
        $display("test interrupt done");
        wr(8'h08, 32'h81);
        @(posedge clk);
        raw_cmd <= 4'h3;
        repeat (8) @(posedge clk);
        settle;
        chk_sig({7'h0, gate[1]}, 8'h00);
        @(posedge clk);
        trun <= 1'b1;
        n = 0;
        while (gate[1] !== 1'b1 && n < 20) begin
            settle;
            n++;
        end
        // Fall three edges after start, then seen and captured
        chk_sig(8'(n), 8'h05);
        $display("test sync done");
        end_of_test;
    end
endmodule : tb
